// File: hw/sfau_top.sv
// segmented flash access unit: read, program, erase and id of a parallel nor flash
`default_nettype none

module sfau_top
   import sfau_pkg::*;
#(
   parameter logic [31:0] PROG_TIMEOUT  = 32'(sfau_pkg::PROG_TIMEOUT_CYC),
   parameter logic [31:0] ERASE_TIMEOUT = 32'(sfau_pkg::ERASE_TIMEOUT_CYC)
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              req_valid,
   input  wire sfau_pkg::sfau_op_t req_op,
   input  wire logic [15:0]       req_seg,
   input  wire logic [15:0]       req_off,
   input  wire logic [7:0]        req_data,
   output logic                   busy,
   output logic                   done,
   output logic [7:0]             result,
   output logic [15:0]            rd_data,
   output logic [18:0]            flash_addr,
   output logic [7:0]             flash_dq_out,
   output logic                   flash_dq_oe_n,
   input  wire logic [7:0]        flash_dq_in,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n
);
   import sfau_pkg::*;

   sfau_state_t   state;
   sfau_state_t   next_state;
   sfau_op_t      op;
   sfau_op_t      sel_op;
   logic [2:0]    step;
   logic [2:0]    next_step;
   logic          polling;
   logic          next_poll;
   logic          aborting;
   logic          next_abort;
   logic [5:0]    cnt;
   logic [18:0]   target;
   logic [18:0]   sel_tgt;
   logic [7:0]    wdata;
   logic [7:0]    sel_dat;
   logic [7:0]    expect_byte;
   logic [7:0]    id_lo;
   logic [7:0]    dq_sync;
   logic [31:0]   timer;
   logic [31:0]   limit;
   logic [19:0]   phys;
   logic          seg_ok;
   logic          launch;
   logic          finish;
   logic          load_lo;
   logic          load_rd;
   logic [7:0]    fin_code;
   logic [15:0]   fin_rdata;
   logic [26:0]   scr;

   // builds one command or read cycle of the current operation's script
   function automatic logic [26:0] script(input sfau_op_t fop, input logic [2:0] st,
                                          input logic poll, input logic [18:0] tgt,
                                          input logic [7:0] dat);
      logic [7:0] cmd;
      cmd = (fop == OP_BYTE_PROGRAM) ? CMD_PROGRAM :
            (fop == OP_SECTOR_ERASE) ? CMD_ERASE_SETUP : CMD_AUTOSELECT;
      if (poll || fop == OP_BYTE_READ) begin
         return {tgt, dat};
      end
      case (st)
         3'h0: return {CMD_ADDR_1, CMD_UNLOCK_1};
         3'h1: return {CMD_ADDR_2, CMD_UNLOCK_2};
         3'h2: return {CMD_ADDR_1, cmd};
         3'h3: return (fop == OP_IDENT_READ) ? {ID_MFR_ADDR, dat} :
                      (fop == OP_SECTOR_ERASE) ? {CMD_ADDR_1, CMD_UNLOCK_1} : {tgt, dat};
         3'h4: return (fop == OP_IDENT_READ) ? {ID_DEV_ADDR, dat} : {CMD_ADDR_2, CMD_UNLOCK_2};
         3'h5: return {tgt, CMD_SECTOR_ERASE};
         STEP_RESET: return {CMD_ADDR_1, CMD_RESET};
         default: return {tgt, dat};
      endcase
   endfunction : script

   // flash data pins arrive from outside the clock domain
   sfau_sync #(.W(8)) u_dq_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (flash_dq_in),
      .q    (dq_sync)
   );

   // address forming and segment check
   assign phys   = {req_seg, 4'h0} + {4'h0, req_off};
   assign seg_ok = (req_seg[11:0] == SEG_ALIGN) && (req_seg >= SEG_LO)
                   && (req_seg <= SEG_HI);
   assign expect_byte = (op == OP_SECTOR_ERASE) ? ERASED_BYTE : wdata;
   assign limit  = (op == OP_SECTOR_ERASE) ? ERASE_TIMEOUT : PROG_TIMEOUT;
   assign scr    = script(sel_op, next_step, next_poll, sel_tgt, sel_dat);

   // sequencing decisions; finish drops back to idle with a result
   always_comb begin
      next_state = state;
      next_step  = step;
      next_poll  = polling;
      next_abort = aborting;
      launch     = 1'b0;
      finish     = 1'b0;
      load_lo    = 1'b0;
      load_rd    = 1'b0;
      fin_code   = RESULT_OK;
      fin_rdata  = rd_data;
      sel_op     = op;
      sel_tgt    = target;
      sel_dat    = wdata;
      case (state)
         ST_IDLE: begin
            sel_op     = req_op;
            sel_dat    = req_data;
            sel_tgt    = (req_op == OP_SECTOR_ERASE) ? {req_seg[14:12], 16'h0000}
                                                     : phys[FLASH_AW-1:0];
            next_step  = 3'h0;
            next_poll  = 1'b0;
            next_abort = 1'b0;
            if (req_valid) begin
               // answers that need no flash cycle come back on the next edge
               if (req_op == OP_BYTE_READ && !phys[PHYS_AW-1]) begin
                  finish    = 1'b1;
                  fin_rdata = {8'h00, UNMAPPED_BYTE};
               end else if (req_op == OP_SECTOR_ERASE && req_seg == SEG_OS) begin
                  finish = 1'b1;
               end else if (req_op inside {OP_BYTE_PROGRAM, OP_SECTOR_ERASE} && !seg_ok) begin
                  finish   = 1'b1;
                  fin_code = RESULT_BAD_SEGMENT;
               end else begin
                  launch     = 1'b1;
                  next_state = (req_op == OP_BYTE_READ) ? ST_READ : ST_WRITE;
               end
            end
         end
         ST_WRITE: begin
            if (cnt == WR_LAST) begin
               launch = 1'b1;
               if (step == STEP_RESET) begin
                  launch     = 1'b0;
                  finish     = 1'b1;
                  next_state = ST_IDLE;
                  fin_code   = aborting ? RESULT_TIMEOUT : RESULT_OK;
               end else if (op == OP_IDENT_READ && step == ID_CMD_LAST) begin
                  next_step  = step + 3'h1;
                  next_state = ST_READ;
               end else if ((op == OP_BYTE_PROGRAM && step == PROG_LAST_STEP) ||
                            (op == OP_SECTOR_ERASE && step == ERASE_LAST_STEP)) begin
                  next_poll  = 1'b1;
                  next_state = ST_READ;
               end else begin
                  next_step = step + 3'h1;
               end
            end
         end
         ST_READ: begin
            if (cnt == RD_LAST) begin
               if (op == OP_BYTE_READ) begin
                  finish     = 1'b1;
                  fin_rdata  = {8'h00, dq_sync};
                  next_state = ST_IDLE;
               end else if (polling) begin
                  // no status pre-check: a bit that cannot rise never matches
                  if (dq_sync == expect_byte) begin
                     finish     = 1'b1;
                     next_poll  = 1'b0;
                     next_state = ST_IDLE;
                  end else if (timer >= limit) begin
                     launch     = 1'b1;
                     next_poll  = 1'b0;
                     next_abort = 1'b1;
                     next_step  = STEP_RESET;
                     next_state = ST_WRITE;
                  end else begin
                     launch = 1'b1;
                  end
               end else if (step == ID_MFR_STEP) begin
                  load_lo   = 1'b1;
                  launch    = 1'b1;
                  next_step = step + 3'h1;
               end else begin
                  load_rd    = 1'b1;
                  fin_rdata  = {dq_sync, id_lo};
                  launch     = 1'b1;
                  next_step  = STEP_RESET;
                  next_state = ST_WRITE;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // sequencer state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state    <= ST_IDLE;
         step     <= 3'h0;
         polling  <= 1'b0;
         aborting <= 1'b0;
         cnt      <= 6'h00;
      end else begin
         state    <= next_state;
         step     <= next_step;
         polling  <= next_poll;
         aborting <= next_abort;
         cnt      <= launch ? 6'h00 : cnt + 6'h01;
      end
   end

   // request capture, only when idle so a busy unit ignores new requests
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op     <= OP_BYTE_READ;
         target <= '0;
         wdata  <= 8'h00;
      end else if (state == ST_IDLE && req_valid) begin
         op     <= req_op;
         target <= sel_tgt;
         wdata  <= req_data;
      end
   end

   // completion timer; resolution is one clock cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timer <= 32'h0000_0000;
      end else if (!polling) begin
         timer <= 32'h0000_0000;
      end else if (timer != 32'hffff_ffff) begin
         timer <= timer + 32'h0000_0001;
      end
   end

   // flash pins; write strobe sits one cycle inside the cycle for setup
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flash_addr    <= '0;
         flash_dq_out  <= 8'h00;
         flash_dq_oe_n <= 1'b1;
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
      end else begin
         flash_addr    <= launch ? scr[26:8] : flash_addr;
         flash_dq_out  <= launch ? scr[7:0] : flash_dq_out;
         flash_dq_oe_n <= (state != ST_WRITE);
         flash_ce_n    <= (state == ST_IDLE);
         flash_oe_n    <= (state != ST_READ);
         flash_we_n    <= !(state == ST_WRITE && cnt >= WE_FIRST && cnt <= WE_LAST);
      end
   end

   // host side answers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy    <= 1'b0;
         done    <= 1'b0;
         result  <= RESULT_OK;
         rd_data <= 16'h0000;
         id_lo   <= 8'h00;
      end else begin
         busy <= (next_state != ST_IDLE);
         done <= finish;
         result  <= finish ? fin_code : result;
         rd_data <= (finish || load_rd) ? fin_rdata : rd_data;
         id_lo   <= load_lo ? dq_sync : id_lo;   // maker byte waits for the device byte
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   bad_seg_prog_a: assert property (state == ST_IDLE && req_valid
      && req_op == OP_BYTE_PROGRAM && !seg_ok |=> done && result == RESULT_BAD_SEGMENT)
      else $error("bad segment program not refused");
   os_erase_skip_a: assert property (state == ST_IDLE && req_valid
      && req_op == OP_SECTOR_ERASE && req_seg == SEG_OS
      |=> done && result == RESULT_OK && !busy ##0 flash_we_n [*4])
      else $error("system sector erase touched flash");
   erase_sector_a: assert property (!flash_we_n && op == OP_SECTOR_ERASE
      && step == ERASE_LAST_STEP && !polling |-> flash_addr[15:0] == 16'h0000
      && flash_dq_out == CMD_SECTOR_ERASE)
      else $error("erase command not at a sector base");
   os_guard_a: assert property (!flash_we_n && op == OP_SECTOR_ERASE
      && step == ERASE_LAST_STEP |-> flash_addr[18:16] != 3'h7)
      else $error("erase aimed at system sector");
   erase_result_a: assert property (done && op == OP_SECTOR_ERASE
      |-> result == RESULT_OK || result == RESULT_TIMEOUT || result == RESULT_BAD_SEGMENT)
      else $error("erase result code out of set");
   erase_ff_a: assert property (state == ST_READ && polling && cnt == RD_LAST
      && op == OP_SECTOR_ERASE && dq_sync != ERASED_BYTE |=> !done)
      else $error("erase finished without 0xff readback");
   stuck_timeout_a: assert property (state == ST_READ && polling && cnt == RD_LAST
      && dq_sync != expect_byte && timer >= limit
      |=> aborting && state == ST_WRITE ##(WR_LAST + 1) done && result == RESULT_TIMEOUT)
      else $error("timeout not reported");
   id_word_a: assert property (done && op == OP_IDENT_READ
      |-> rd_data[7:0] == id_lo && result == RESULT_OK)
      else $error("id word layout wrong");
   unmapped_rd_a: assert property (state == ST_IDLE && req_valid
      && req_op == OP_BYTE_READ && !phys[PHYS_AW-1] |=> done && rd_data == 16'h00ff)
      else $error("unmapped read not 0xff");
   addr_form_a: assert property (state == ST_IDLE && req_valid
      && req_op == OP_BYTE_READ && phys[PHYS_AW-1]
      |=> flash_addr == $past(phys[FLASH_AW-1:0]))
      else $error("flash address mis-formed");

   prog_ok_c: cover property (done && op == OP_BYTE_PROGRAM && result == RESULT_OK);
   erase_ok_c: cover property (done && op == OP_SECTOR_ERASE && result == RESULT_OK
      && flash_ce_n);
   prog_tmo_c: cover property (done && op == OP_BYTE_PROGRAM && result == RESULT_TIMEOUT);
   id_read_c: cover property (done && op == OP_IDENT_READ);

endmodule : sfau_top

`default_nettype wire

// File: hw/sfau_pkg.sv
// constants and types shared by the segmented flash access unit
`default_nettype none

package sfau_pkg;

   // clock and bus-cycle timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned CLK_MHZ       = 250;
   localparam int unsigned T_WE_LOW_NS   = 40;
   localparam int unsigned T_WE_HIGH_NS  = 20;
   localparam int unsigned T_READ_NS     = 70;
   localparam int unsigned WE_LOW_CYC    = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WE_HIGH_CYC   = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned READ_CYC      = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SYNC_LAT_CYC  = 2;
   localparam logic [5:0]  WE_FIRST      = 6'h01;
   localparam logic [5:0]  WE_LAST       = 6'(WE_LOW_CYC);
   localparam logic [5:0]  WR_LAST       = 6'(WE_LOW_CYC + WE_HIGH_CYC);
   localparam logic [5:0]  RD_LAST       = 6'(READ_CYC + SYNC_LAT_CYC + 1);

   // completion timeouts
   localparam int unsigned     PROG_TIMEOUT_US   = 300;
   localparam int unsigned     PROG_TIMEOUT_CYC  = PROG_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned     ERASE_TIMEOUT_MS  = 15000;
   localparam longint unsigned ERASE_TIMEOUT_CYC = longint'(ERASE_TIMEOUT_MS) * CLK_MHZ * 1000;

   // geometry: 512K flash in the upper half of a 1M space, 64K sectors
   localparam int unsigned FLASH_BYTES = 524288;
   localparam int unsigned SECTOR_BYTES = 65536;
   localparam int unsigned FLASH_AW    = 19;
   localparam int unsigned PHYS_AW     = 20;
   localparam logic [15:0] SEG_LO      = 16'h8000;
   localparam logic [15:0] SEG_HI      = 16'he000;
   localparam logic [15:0] SEG_OS      = 16'hf000;
   localparam logic [11:0] SEG_ALIGN   = 12'h000;
   localparam logic [7:0]  ERASED_BYTE = 8'hff;
   localparam logic [7:0]  UNMAPPED_BYTE = 8'hff;

   // result codes, two's complement
   localparam logic [7:0] RESULT_OK          = 8'h00;
   localparam logic [7:0] RESULT_TIMEOUT     = 8'hfb;
   localparam logic [7:0] RESULT_BAD_SEGMENT = 8'hf4;

   // flash command cycles
   localparam logic [18:0] CMD_ADDR_1      = 19'h00555;
   localparam logic [18:0] CMD_ADDR_2      = 19'h002aa;
   localparam logic [18:0] ID_MFR_ADDR     = 19'h00000;
   localparam logic [18:0] ID_DEV_ADDR     = 19'h00001;
   localparam logic [7:0]  CMD_UNLOCK_1    = 8'haa;
   localparam logic [7:0]  CMD_UNLOCK_2    = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
   localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0]  CMD_AUTOSELECT  = 8'h90;
   localparam logic [7:0]  CMD_RESET       = 8'hf0;

   // script step numbers
   localparam logic [2:0] PROG_LAST_STEP  = 3'h3;
   localparam logic [2:0] ERASE_LAST_STEP = 3'h5;
   localparam logic [2:0] ID_CMD_LAST     = 3'h2;
   localparam logic [2:0] ID_MFR_STEP     = 3'h3;
   localparam logic [2:0] STEP_RESET      = 3'h7;

   typedef enum logic [1:0] {
      OP_BYTE_READ    = 2'h0,
      OP_BYTE_PROGRAM = 2'h1,
      OP_SECTOR_ERASE = 2'h2,
      OP_IDENT_READ   = 2'h3
   } sfau_op_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } sfau_state_t;

endpackage : sfau_pkg

`default_nettype wire

// File: hw/sfau_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none

module sfau_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : sfau_sync

`default_nettype wire

// File: bench/sfau_flash_model.sv
// behavioural parallel nor flash that answers the access unit
`default_nettype none

module sfau_flash_model
   import sfau_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE  = 8'h3d, // arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'h6e, // arbitrary value
   parameter int         RD_NS       = 60
) (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [18:0] addr,
   input  wire logic [7:0]  dq_wr,
   input  wire logic        dq_oe_n,
   input  wire logic        stall_erase,
   output logic      [7:0]  dq_rd,
   output int               erase_count
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [FLASH_BYTES];
   logic [2:0] step;
   logic       ident;
   logic [7:0] last;
   logic [7:0] word;

   // array ships erased, command decoder idle
   initial begin
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      step = 3'h0;
      ident = 1'b0;
      erase_count = 0;
      last = 8'h00;
   end

   // commands latch on the rising edge of write enable
   always @(posedge we_n) begin
      if (!ce_n && !dq_oe_n) begin
         if (dq_wr == CMD_RESET) begin
            step = 3'h0;
            ident = 1'b0;
         end else begin
            case (step)
               3'h0, 3'h4: step = (addr == CMD_ADDR_1 && dq_wr == CMD_UNLOCK_1) ? step + 3'h1 : 3'h0;
               3'h1, 3'h5: step = (addr == CMD_ADDR_2 && dq_wr == CMD_UNLOCK_2) ? step + 3'h1 : 3'h0;
               3'h2: begin
                  ident = (dq_wr == CMD_AUTOSELECT);
                  step = (dq_wr == CMD_PROGRAM) ? 3'h3 : (dq_wr == CMD_ERASE_SETUP) ? 3'h4 : 3'h0;
               end
               3'h3: begin
                  mem[addr] = mem[addr] & dq_wr; // no pre-check, ones never come back
                  step = 3'h0;
               end
               default: begin
                  if (dq_wr == CMD_SECTOR_ERASE) begin
                     erase_count++;
                  end
                  // a stalled erase leaves the sector as it was, so polling never matches
                  if (dq_wr == CMD_SECTOR_ERASE && !stall_erase) begin
                     for (int i = 0; i < SECTOR_BYTES; i++) begin
                        mem[{addr[18:16], 16'(i)}] = ERASED_BYTE;
                     end
                  end
                  step = 3'h0;
               end
            endcase
         end
      end
   end

   // read path; a released bus shows the inverse of the last byte, not a stale copy
   assign word = ident ? ((addr == ID_DEV_ADDR) ? DEVICE_CODE : MAKER_CODE) : mem[addr];
   assign #RD_NS dq_rd = (!ce_n && !oe_n) ? word : ~last;

   always @(dq_rd) begin
      if (!ce_n && !oe_n) last = dq_rd;
   end

endmodule : sfau_flash_model

`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the segmented flash access unit
`default_nettype none

module tb;
   import sfau_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam sfau_op_t RD = OP_BYTE_READ;
   localparam sfau_op_t PG = OP_BYTE_PROGRAM;
   localparam sfau_op_t ER = OP_SECTOR_ERASE;
   localparam sfau_op_t ID = OP_IDENT_READ;

   typedef struct {
      sfau_op_t    op;
      logic [15:0] seg;
      logic [15:0] off;
      logic [7:0]  dat;
      logic [7:0]  res;
      logic [15:0] rd;
   } sfau_row_t;

   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        req_valid = 1'b0;
   sfau_op_t    req_op = RD;
   logic [15:0] req_seg = 16'h0;
   logic [15:0] req_off = 16'h0;
   logic [7:0]  req_data = 8'h0;
   logic        busy, done, ce_n, oe_n, we_n, dq_oe_n, stall_erase = 1'b0;
   logic [7:0]  result, dq_out, dq_in, res;
   logic [15:0] rd_data, rd;
   logic [18:0] faddr;
   int          erase_count, bad_count = 0, compares = 0, cycles = 0;

   // ordinary cases; rd is compared only for reads
   sfau_row_t rows [21] = '{
      '{ER, 16'h8000, 16'h0000, 8'h00, 8'h00, 16'h0000}, '{RD, 16'h8000, 16'h0010, 8'h00, 8'h00, 16'h00ff},
      '{PG, 16'h8000, 16'h0010, 8'h5a, 8'h00, 16'h0000}, '{RD, 16'h8000, 16'h0010, 8'h00, 8'h00, 16'h005a},
      '{PG, 16'h8000, 16'h0010, 8'hff, 8'hfb, 16'h0000}, '{RD, 16'h8000, 16'h0010, 8'h00, 8'h00, 16'h005a},
      '{PG, 16'h8800, 16'h0000, 8'h00, 8'hf4, 16'h0000}, '{PG, 16'hf000, 16'h0000, 8'h00, 8'hf4, 16'h0000},
      '{PG, 16'h7000, 16'h0000, 8'h00, 8'hf4, 16'h0000}, '{ER, 16'h8100, 16'h0000, 8'h00, 8'hf4, 16'h0000},
      '{ER, 16'hf000, 16'h0000, 8'h00, 8'h00, 16'h0000}, '{ID, 16'h0000, 16'h0000, 8'h00, 8'h00, 16'h6e3d},
      '{RD, 16'h0000, 16'h0000, 8'h00, 8'h00, 16'h00ff}, '{PG, 16'h9000, 16'h000f, 8'h3c, 8'h00, 16'h0000},
      '{RD, 16'h8001, 16'hffff, 8'h00, 8'h00, 16'h003c}, '{PG, 16'he000, 16'hffff, 8'h00, 8'h00, 16'h0000},
      '{RD, 16'he000, 16'hffff, 8'h00, 8'h00, 16'h0000}, '{ER, 16'h9000, 16'h0000, 8'h00, 8'h00, 16'h0000},
      '{RD, 16'h9000, 16'h000f, 8'h00, 8'h00, 16'h00ff}, '{RD, 16'h8000, 16'h0010, 8'h00, 8'h00, 16'h005a},
      '{PG, 16'h8000, 16'h0000, 8'h00, 8'h00, 16'h0000}};

   always #2 clk = ~clk;

   // small timeouts keep the failing polls short
   sfau_top #(.PROG_TIMEOUT(32'd200), .ERASE_TIMEOUT(32'd400)) u_dut (
      .clk(clk), .rstn(rstn), .req_valid(req_valid), .req_op(req_op), .req_seg(req_seg),
      .req_off(req_off), .req_data(req_data), .busy(busy), .done(done), .result(result),
      .rd_data(rd_data), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
      .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));

   sfau_flash_model u_flash (
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr), .dq_wr(dq_out), .dq_oe_n(dq_oe_n),
      .stall_erase(stall_erase), .dq_rd(dq_in), .erase_count(erase_count));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // one request, then a bounded wait for done; poke re-strobes while busy
   task automatic do_req(input sfau_op_t op, input logic [15:0] seg, input logic [15:0] off,
                         input logic [7:0] dat, input bit poke);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_seg <= seg;
      req_off <= off;
      req_data <= dat;
      n = 0;
      while (n < 3000) begin
         @(posedge clk);
         req_valid <= (poke && n == 5);
         #1;
         if (done === 1'b1) break;
         n++;
      end
      if (n == 3000) check("done wait", 16'h0, 16'h1);
      res = result;
      rd = rd_data;
   endtask : do_req

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         complete_run();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      check("reset state", {2'b0, busy, done, ce_n, oe_n, we_n, dq_oe_n, result}, 16'h0f00);
      foreach (rows[i]) begin
         do_req(rows[i].op, rows[i].seg, rows[i].off, rows[i].dat, 1'b0);
         check("result", {8'h00, res}, {8'h00, rows[i].res});
         if (rows[i].op inside {RD, ID}) check("read data", rd, rows[i].rd);
         $display("test row %0d done", i);
      end
      // erase that never finishes must time out and keep the programmed zero
      stall_erase = 1'b1;
      do_req(ER, 16'h8000, 16'h0, 8'h0, 1'b0);
      check("stalled erase", {8'h00, res}, 16'h00fb);
      stall_erase = 1'b0;
      do_req(RD, 16'h8000, 16'h0, 8'h0, 1'b0);
      check("after stall", rd, 16'h0000);
      $display("test stalled erase done");
      // a strobe while busy is dropped: one answer only
      do_req(ER, 16'ha000, 16'h0, 8'h0, 1'b1);
      check("busy erase", {8'h00, res}, 16'h0000);
      repeat (3) @(posedge clk);
      #1;
      check("no second done", {14'h0, busy, done}, 16'h0);
      check("erase cycles", 16'(erase_count), 16'h0004);
      $display("test busy strobe done");
      // reset in mid read drops every output to idle at once
      do_req(RD, 16'h8000, 16'h0, 8'h0, 1'b0);
      @(posedge clk);
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b0;
      #1;
      check("mid reset", {2'b0, busy, done, ce_n, oe_n, we_n, dq_oe_n, result}, 16'h0f00);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      do_req(RD, 16'h8000, 16'h0010, 8'h0, 1'b0);
      check("read after reset", rd, 16'h005a);
      $display("test mid reset done");
      complete_run();
   end

endmodule : tb

`default_nettype wire
